// ==== src/oag_pkg.sv ====
// Shared constants and types for the operand address generator.
// Assumes a 16-bit address space and big-endian multi-byte operands.
package oag_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          OAG_AW       = 16;    // Address width
  localparam int          OAG_PTR_NUM  = 4;     // Pointer register count
  localparam logic [7:0]  OAG_PAGE_RST = 8'h00; // Page base after reset
  localparam logic [15:0] OAG_PTR_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Postbyte field positions and codes
  // ----------------------------------------------------------------
  localparam int OAG_PB_IDX_BIT = 7;  // Set: nibble-coded variation
  localparam int OAG_PB_IND_BIT = 4;  // Indirect flag / 5-bit sign
  localparam int OAG_PB_SEL_HI  = 6;  // Pointer select field, upper
  localparam int OAG_PB_SEL_LO  = 5;  // Pointer select field, lower
  localparam logic [7:0] OAG_PB_EXT_IND = 8'h9F; // Extended indirect

  localparam logic [3:0] OAG_NIB_INC1   = 4'h0;
  localparam logic [3:0] OAG_NIB_INC2   = 4'h1;
  localparam logic [3:0] OAG_NIB_DEC1   = 4'h2;
  localparam logic [3:0] OAG_NIB_DEC2   = 4'h3;
  localparam logic [3:0] OAG_NIB_ZERO   = 4'h4;
  localparam logic [3:0] OAG_NIB_ACC_LO = 4'h5;
  localparam logic [3:0] OAG_NIB_ACC_HI = 4'h6;
  localparam logic [3:0] OAG_NIB_OFF8   = 4'h8;
  localparam logic [3:0] OAG_NIB_OFF16  = 4'h9;
  localparam logic [3:0] OAG_NIB_ACC_D  = 4'hB;
  localparam logic [3:0] OAG_NIB_PC8    = 4'hC;
  localparam logic [3:0] OAG_NIB_PC16   = 4'hD;
  localparam logic [3:0] OAG_NIB_EXT    = 4'hF;

  // ----------------------------------------------------------------
  // Extra cycle counts per variation, entry n is nibble n
  // ----------------------------------------------------------------
  localparam logic [15:0][3:0] OAG_CYC_TBL = {
    4'h0, 4'h0, 4'h5, 4'h1, 4'h4, 4'h0, 4'h4, 4'h1,
    4'h0, 4'h1, 4'h1, 4'h0, 4'h3, 4'h2, 4'h3, 4'h2};
  localparam logic [3:0] OAG_CYC_OFF5    = 4'h1; // 5-bit offset form
  localparam logic [3:0] OAG_CYC_IND     = 4'h3; // Added by indirection
  localparam logic [3:0] OAG_CYC_EXT_IND = 4'h5; // Extended indirect
  localparam logic [1:0] OAG_BYTES_EXT   = 2'h2; // Extended address

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OAG_MODE_INH, OAG_MODE_IMM, OAG_MODE_EXT,
    OAG_MODE_DIR, OAG_MODE_REG, OAG_MODE_IDX
  } oag_mode_t;

  typedef struct packed {
    oag_mode_t   mode;  // Addressing mode from the opcode
    logic        wide;  // Immediate operand is two bytes
    logic [15:0] pc;    // Address of the byte after the opcode
  } oag_req_t;

  typedef struct packed {
    logic [15:0] ea;          // Final operand address
    logic [15:0] next_pc;     // Address after all consumed bytes
    logic [15:0] ptr_value;   // Selected pointer after any update
    logic [7:0]  postbyte;    // Postbyte, zero when none fetched
    logic [3:0]  extra_cyc;   // Extra cycles of the variation
    logic [1:0]  extra_bytes; // Extra bytes of the variation
    logic        undef;       // Undefined postbyte seen
  } oag_res_t;

endpackage

// ==== src/oag_ptr_mem.sv ====
// Pointer register storage: four 16-bit entries, one write port,
// one read port whose data come out of a register.
// Assumes writes and reads are on the same processor clock.
`timescale 1ns/1ps
module oag_ptr_mem
  import oag_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_wr,
  input  wire logic [1:0]  i_waddr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [1:0]  i_raddr,
  output logic [15:0]      o_rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mem_reg  [OAG_PTR_NUM];  // Entries
  logic [15:0] mem_next [OAG_PTR_NUM];  // Next entry values
  logic [15:0] rd_next;                 // Next read data

  // One entry per loop pass; each only reacts to its own address
  for (genvar g = 0; g < OAG_PTR_NUM; g++) begin : g_ent
    always_comb begin
      mem_next[g] = mem_reg[g];
      if (i_wr && (i_waddr == 2'(g))) begin
        mem_next[g] = i_wdata;
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        mem_reg[g] <= OAG_PTR_RST;
      end else begin
        mem_reg[g] <= mem_next[g];
      end
    end
  end

  // Read data registered, so old value is seen on a same-cycle write
  always_comb begin
    rd_next = mem_reg[i_raddr];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= OAG_PTR_RST;
    end else begin
      o_rdata <= rd_next;
    end
  end

endmodule

// ==== src/oag_core.sv ====
// Operand effective address generator.
// Assumes the decode stage gives one request at a time while idle and
// a memory read port that answers each read with a one-cycle ack.
//
// Summary of operation
// - Inherent mode: no address bytes fetched
// - Immediate operand is next one or two bytes
// - Extended: two following bytes form absolute address
// - Postbyte 9F: fetched address holds effective address
// - Direct: page base high, fetched byte low
// - Page base register clears to zero on reset
// - Direct mode never uses indirection
// - Register mode fetches one postbyte selecting registers
// - Bit7 clear: add signed 5-bit offset, no bytes
// - Bits 6:5 pick pointer: X, Y, U, S
// - Bit7 set: bit4 indirect, bits 3:0 variation
// - Nibble 0100 uses pointer directly
// - Constant offsets: one or two bytes, pointer kept
// - Accumulator offsets added signed, nothing modified
// - Auto increment: use pointer, then add one/two
// - Auto decrement: subtract first, then use it
// - PC relative adds 8/16-bit offset to PC
// - Indirect reads high byte first as final address
// - No indirection for by-one or 5-bit forms
// - Hold address, update pointer, report updated pointer
// - Report extra cycles and bytes per variation
// - All address arithmetic wraps at 16 bits
`timescale 1ns/1ps
module oag_core
  import oag_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req,        // Request strobe, idle only
  input  wire oag_req_t    i_req_data,   // Mode, size, start address
  input  wire logic [7:0]  i_high_accumulator,
  input  wire logic [7:0]  i_low_accumulator,
  input  wire logic        i_ptr_wr,     // Load a pointer register
  input  wire logic [1:0]  i_ptr_sel,
  input  wire logic [15:0] i_ptr_data,
  input  wire logic        i_page_wr,    // Load the page base
  input  wire logic [7:0]  i_page_data,
  input  wire logic        i_mem_ack,    // Read data valid
  input  wire logic [7:0]  i_mem_data,
  output logic             o_mem_rd,     // Read request level
  output logic [15:0]      o_mem_addr,
  output logic             o_busy,
  output logic             o_done,       // Result valid, one cycle
  output oag_res_t         o_res,
  output logic [7:0]       o_page_base_register
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_POST, S_OPND, S_PTR, S_CALC, S_IND, S_DONE
  } oag_state_t;

  oag_state_t  state_reg,  state_next;    // Sequencer
  oag_mode_t   mode_reg,   mode_next;     // Mode in progress
  logic [15:0] pc_reg,     pc_next;       // Instruction byte address
  logic [15:0] ind_reg,    ind_next;      // Indirect read address
  logic [7:0]  post_reg,   post_next;     // Postbyte
  logic [15:0] buf_reg,    buf_next;      // Fetched bytes, big-endian
  logic [1:0]  cnt_reg,    cnt_next;      // Bytes still to fetch
  logic [7:0]  page_reg,   page_next;     // Page base register
  oag_res_t    res_reg,    res_next;      // Result holding register

  logic [15:0] ptr_rdata;                 // Selected pointer value
  logic        ptr_upd;                   // Auto update this cycle
  logic [15:0] ptr_new;                   // Updated pointer value
  logic [15:0] ea_calc;                   // Indexed address
  logic        undef;                     // Undefined postbyte
  logic        ind;                       // Indirection taken
  logic [3:0]  nib;                       // Variation nibble
  logic [15:0] off5;                      // Sign-extended 5-bit offset
  logic [15:0] off8;                      // Sign-extended byte offset
  logic [15:0] base;                      // Pointer or PC
  logic        wr_en;                     // Pointer memory write
  logic [1:0]  wr_addr;
  logic [15:0] wr_data;

  // ----------------------------------------------------------------
  // Offset bytes that follow a postbyte
  // ----------------------------------------------------------------
  function automatic logic [1:0] off_bytes(input logic [7:0] pb);
    logic [1:0] n;
    n = 2'h0;
    if (pb[OAG_PB_IDX_BIT]) begin
      case (pb[3:0])
        OAG_NIB_OFF8, OAG_NIB_PC8:   n = 2'h1;
        OAG_NIB_OFF16, OAG_NIB_PC16: n = 2'h2;
        OAG_NIB_EXT: begin
          // Only the exact code carries an address; others fetch none
          if (pb == OAG_PB_EXT_IND) begin
            n = OAG_BYTES_EXT;
          end
        end
        default:                     n = 2'h0;
      endcase
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Pointer storage; external loads yield to auto updates
  // ----------------------------------------------------------------
  assign wr_en   = ptr_upd | i_ptr_wr;
  assign wr_addr = ptr_upd ? post_reg[OAG_PB_SEL_HI:OAG_PB_SEL_LO]
                           : i_ptr_sel;
  assign wr_data = ptr_upd ? ptr_new : i_ptr_data;

  oag_ptr_mem u_ptr_mem (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (wr_en),
    .i_waddr   (wr_addr),
    .i_wdata   (wr_data),
    .i_raddr   (post_reg[OAG_PB_SEL_HI:OAG_PB_SEL_LO]),
    .o_rdata   (ptr_rdata)
  );

  // ----------------------------------------------------------------
  // Indexed address arithmetic, all 16-bit and wrapping
  // ----------------------------------------------------------------
  always_comb begin
    nib     = post_reg[3:0];
    off5    = {{11{post_reg[OAG_PB_IND_BIT]}}, post_reg[4:0]};
    off8    = {{8{buf_reg[7]}}, buf_reg[7:0]};
    ptr_new = ptr_rdata;
    ptr_upd = 1'b0;
    undef   = 1'b0;
    // PC relative ignores the select field; PC is past the offset
    base    = ((nib == OAG_NIB_PC8) || (nib == OAG_NIB_PC16))
              ? pc_reg : ptr_rdata;
    ea_calc = base;
    if (!post_reg[OAG_PB_IDX_BIT]) begin
      ea_calc = ptr_rdata + off5;
    end else begin
      case (nib)
        OAG_NIB_INC1: begin
          ptr_new = ptr_rdata + 16'h0001;
          ptr_upd = 1'b1;
        end
        OAG_NIB_INC2: begin
          ptr_new = ptr_rdata + 16'h0002;
          ptr_upd = 1'b1;
        end
        OAG_NIB_DEC1: begin
          ptr_new = ptr_rdata - 16'h0001;
          ea_calc = ptr_new;
          ptr_upd = 1'b1;
        end
        OAG_NIB_DEC2: begin
          ptr_new = ptr_rdata - 16'h0002;
          ea_calc = ptr_new;
          ptr_upd = 1'b1;
        end
        OAG_NIB_ZERO:   ea_calc = base;
        OAG_NIB_ACC_LO: ea_calc = base +
                          {{8{i_low_accumulator[7]}}, i_low_accumulator};
        OAG_NIB_ACC_HI: ea_calc = base +
                          {{8{i_high_accumulator[7]}}, i_high_accumulator};
        OAG_NIB_ACC_D:  ea_calc = base +
                          {i_high_accumulator, i_low_accumulator};
        OAG_NIB_OFF8, OAG_NIB_PC8:   ea_calc = base + off8;
        OAG_NIB_OFF16, OAG_NIB_PC16: ea_calc = base + buf_reg;
        OAG_NIB_EXT: begin
          ea_calc = buf_reg;
          undef   = (post_reg != OAG_PB_EXT_IND);
        end
        // Unlisted nibbles: act as zero offset, flagged
        default: undef = 1'b1;
      endcase
      // By-one auto modes have no indirect form
      if (post_reg[OAG_PB_IND_BIT] &&
          ((nib == OAG_NIB_INC1) || (nib == OAG_NIB_DEC1))) begin
        undef = 1'b1;
      end
      if (undef) begin
        ea_calc = ptr_rdata;
        ptr_new = ptr_rdata;
        ptr_upd = 1'b0;
      end
    end
    // Only the CALC cycle commits an update
    if (state_reg != S_CALC) begin
      ptr_upd = 1'b0;
    end
    // 5-bit form never indirect; its bit 4 is a sign bit
    ind = post_reg[OAG_PB_IDX_BIT] & post_reg[OAG_PB_IND_BIT] &
          ~undef;
  end

  // ----------------------------------------------------------------
  // Sequencer next values
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    pc_next    = pc_reg;
    ind_next   = ind_reg;
    post_next  = post_reg;
    buf_next   = buf_reg;
    cnt_next   = cnt_reg;
    page_next  = page_reg;
    res_next   = res_reg;
    // Software loads of the page base only while idle
    if (i_page_wr && (state_reg == S_IDLE)) begin
      page_next = i_page_data;
    end
    case (state_reg)
      S_IDLE: begin
        if (i_req) begin
          mode_next = i_req_data.mode;
          pc_next   = i_req_data.pc;
          post_next = 8'h00;
          buf_next  = 16'h0000;
          res_next  = '0;
          case (i_req_data.mode)
            OAG_MODE_INH: begin
              res_next.next_pc = i_req_data.pc;
              state_next       = S_DONE;
            end
            OAG_MODE_IMM: begin
              res_next.ea      = i_req_data.pc;
              res_next.next_pc = i_req_data.wide
                                 ? i_req_data.pc + 16'h0002
                                 : i_req_data.pc + 16'h0001;
              state_next       = S_DONE;
            end
            OAG_MODE_EXT: begin
              cnt_next   = 2'h2;
              state_next = S_OPND;
            end
            OAG_MODE_DIR: begin
              cnt_next   = 2'h1;
              state_next = S_OPND;
            end
            // Register and indexed forms both start with a postbyte
            default: state_next = S_POST;
          endcase
        end
      end
      S_POST: begin
        if (i_mem_ack) begin
          post_next = i_mem_data;
          pc_next   = pc_reg + 16'h0001;
          res_next.postbyte = i_mem_data;
          if (mode_reg == OAG_MODE_REG) begin
            res_next.next_pc = pc_reg + 16'h0001;
            state_next       = S_DONE;
          end else begin
            cnt_next   = off_bytes(i_mem_data);
            state_next = (off_bytes(i_mem_data) == 2'h0) ? S_PTR
                                                         : S_OPND;
          end
        end
      end
      S_OPND: begin
        if (i_mem_ack) begin
          buf_next = {buf_reg[7:0], i_mem_data};      // High byte first
          pc_next  = pc_reg + 16'h0001;
          cnt_next = cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            res_next.next_pc = pc_reg + 16'h0001;
            if (mode_reg == OAG_MODE_EXT) begin
              res_next.ea = buf_next;
              state_next  = S_DONE;
            end else if (mode_reg == OAG_MODE_DIR) begin
              // No indirect path exists from here
              res_next.ea = {page_reg, i_mem_data};
              state_next  = S_DONE;
            end else begin
              state_next  = S_PTR;
            end
          end
        end
      end
      // Pointer memory answers one cycle after the select is stable
      S_PTR: state_next = S_CALC;
      S_CALC: begin
        // Address held before the pointer is rewritten
        res_next.ea        = ea_calc;
        res_next.ptr_value = ptr_new;
        res_next.next_pc   = pc_reg;
        res_next.undef     = undef;
        res_next.extra_bytes = undef ? 2'h0 : off_bytes(post_reg);
        if (undef) begin
          res_next.extra_cyc = 4'h0;
        end else if (!post_reg[OAG_PB_IDX_BIT]) begin
          res_next.extra_cyc = OAG_CYC_OFF5;
        end else if (post_reg == OAG_PB_EXT_IND) begin
          res_next.extra_cyc = OAG_CYC_EXT_IND;
        end else begin
          res_next.extra_cyc = OAG_CYC_TBL[nib] +
                               (ind ? OAG_CYC_IND : 4'h0);
        end
        if (ind) begin
          ind_next   = ea_calc;
          cnt_next   = 2'h2;
          state_next = S_IND;
        end else begin
          state_next = S_DONE;
        end
      end
      S_IND: begin
        if (i_mem_ack) begin
          buf_next = {buf_reg[7:0], i_mem_data};
          ind_next = ind_reg + 16'h0001;
          cnt_next = cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            res_next.ea = buf_next;
            state_next  = S_DONE;
          end
        end
      end
      S_DONE:  state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= S_IDLE;
      mode_reg  <= OAG_MODE_INH;
      pc_reg    <= 16'h0000;
      ind_reg   <= 16'h0000;
      post_reg  <= 8'h00;
      buf_reg   <= 16'h0000;
      cnt_reg   <= 2'h0;
      page_reg  <= OAG_PAGE_RST;
      res_reg   <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      pc_reg    <= pc_next;
      ind_reg   <= ind_next;
      post_reg  <= post_next;
      buf_reg   <= buf_next;
      cnt_reg   <= cnt_next;
      page_reg  <= page_next;
      res_reg   <= res_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_mem_rd   = (state_reg == S_POST) || (state_reg == S_OPND) ||
                      (state_reg == S_IND);
  assign o_mem_addr = (state_reg == S_IND) ? ind_reg : pc_reg;
  assign o_busy     = (state_reg != S_IDLE);
  assign o_done     = (state_reg == S_DONE);
  assign o_res      = res_reg;
  assign o_page_base_register = page_reg;

endmodule

// ==== tb/oag_mem_model.sv ====
// Memory read port model facing the operand address generator.
// Assumes the bench loads mem by hierarchy before each request.
`timescale 1ns/1ps
module oag_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic [7:0]       o_data
);
  logic [7:0] mem [0:65535]; // Backing store
  logic [7:0] last_reg;      // Last byte answered
  logic [1:0] wait_reg;      // Wait cycles spent on this read
  initial begin
    o_ack = 1'b0;
    last_reg = 8'h00;
    wait_reg = 2'h0;
  end
  // Answer after no wait or three waits (slow memory)
  always @(posedge i_clk) begin
    if (i_rd && !o_ack && (!i_slow || wait_reg == 2'h3)) begin
      o_ack <= 1'b1;
      last_reg <= mem[i_addr];
      wait_reg <= 2'h0;
    end else begin
      o_ack <= 1'b0;
      wait_reg <= (i_rd && !o_ack) ? wait_reg + 2'h1 : 2'h0;
    end
  end
  // Off the answer the bus shows junk, never the last byte
  assign o_data = o_ack ? last_reg : ~last_reg;
endmodule

// ==== tb/oag_core_checker.sv ====
// Concurrent checks on the operand address generator ports.
// Assumes it is bound to oag_core; one clock, sync reset.
`timescale 1ns/1ps
module oag_core_checker
  import oag_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_req,
  input wire oag_req_t    i_req_data,
  input wire logic        i_mem_ack,
  input wire logic        o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire oag_res_t    o_res,
  input wire logic [7:0]  o_page_base_register
);
  oag_mode_t  mode_reg;  // Mode of the request in flight
  oag_mode_t  mode_next;
  logic       take;      // Request accepted this edge
  logic       xd;        // Indexed result on show
  logic [7:0] pb;        // Reported postbyte
  assign take = i_req && !o_busy;
  assign xd = o_done && mode_reg == OAG_MODE_IDX;
  assign pb = o_res.postbyte;
  always_comb begin
    mode_next = take ? i_req_data.mode : mode_reg;
  end
  always_ff @(posedge i_clk) begin
    mode_reg <= i_sys_rst ? OAG_MODE_INH : mode_next;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_inh;
    take && i_req_data.mode == OAG_MODE_INH |=> o_done && !o_mem_rd;
  endproperty
  a_inh: assert property (p_inh)
    else $error("inherent not done at once");
  property p_imm;
    take && i_req_data.mode == OAG_MODE_IMM
      |=> o_done && o_res.ea == $past(i_req_data.pc);
  endproperty
  a_imm: assert property (p_imm)
    else $error("immediate address wrong");
  property p_page;
    $past(i_sys_rst) |-> o_page_base_register == 8'h00;
  endproperty
  a_page: assert property (p_page)
    else $error("page base not cleared");
  property p_dir;
    o_done && mode_reg == OAG_MODE_DIR
      |-> o_res.ea[15:8] == o_page_base_register;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direct high byte wrong");
  property p_hold;
    o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read dropped before answer");
  property p_off5;
    xd && !pb[7] |-> o_res.extra_cyc == 4'h1 && o_res.extra_bytes == 2'h0;
  endproperty
  a_off5: assert property (p_off5)
    else $error("short offset cost wrong");
  property p_extind;
    xd && pb == 8'h9F
      |-> o_res.extra_cyc == 4'h5 && o_res.extra_bytes == 2'h2;
  endproperty
  a_extind: assert property (p_extind)
    else $error("extended indirect cost wrong");
  property p_inc;
    xd && pb[7] && pb[4:0] == 5'h00
      |-> o_res.ptr_value == o_res.ea + 16'h0001;
  endproperty
  a_inc: assert property (p_inc)
    else $error("post increment wrong");
  property p_dec;
    xd && pb[7] && pb[4:0] == 5'h02 |-> o_res.ptr_value == o_res.ea;
  endproperty
  a_dec: assert property (p_dec)
    else $error("pre decrement wrong");
  property p_bound;
    take |-> ##[1:80] o_done;
  endproperty
  a_bound: assert property (p_bound)
    else $error("request never finished");
  property p_pulse;
    o_done |=> !o_done && !o_busy;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("done not one cycle");
  c_ind: cover property (xd && pb[7] && pb[4]);
  c_auto: cover property (xd && pb[7] && pb[3:2] == 2'h0);
  c_slow: cover property (o_mem_rd && !i_mem_ack ##1 o_mem_rd);
endmodule
bind oag_core oag_core_checker u_oag_core_checker (.*);

// ==== tb/tb_oag_core.sv ====
// Self-checking bench for the operand address generator.
// Assumes the memory model answers reads; bench plays decode stage.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_oag_core
  import oag_pkg::*;
;
  logic        i_clk, i_sys_rst, i_req, i_ptr_wr, i_page_wr, slow;
  logic        i_mem_ack, o_mem_rd, o_busy, o_done;
  logic [1:0]  i_ptr_sel;
  logic [7:0]  hi_acc, lo_acc, i_page_data, i_mem_data, o_page_base_register;
  logic [15:0] i_ptr_data, o_mem_addr;
  oag_req_t    i_req_data;
  oag_res_t    o_res;
  int          err_total, n_compared;
  oag_core u_oag_core (.*, .i_high_accumulator(hi_acc),
    .i_low_accumulator(lo_acc));
  oag_mem_model u_mem (.i_clk(i_clk), .i_rd(o_mem_rd), .i_addr(o_mem_addr),
    .i_slow(slow), .o_ack(i_mem_ack), .o_data(i_mem_data));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Request one pulse, wait bounded for done, let done edge pass
  task automatic go(input oag_mode_t m, input logic w, input logic [15:0] pc);
    @(posedge i_clk) #1;
    i_req = 1'b1;
    i_req_data = '{mode: m, wide: w, pc: pc};
    @(posedge i_clk) #1;
    i_req = 1'b0;
    repeat (200) begin
      if (o_done === 1'b1) break;
      @(posedge i_clk) #1;
    end
    `CHK("done", 1'b1, o_done)
    @(posedge i_clk) #1;
  endtask
  task automatic idx(input logic [7:0] p, b1, b2, input logic [15:0] pc);
    u_mem.mem[pc] = p;
    u_mem.mem[pc + 16'h1] = b1;
    u_mem.mem[pc + 16'h2] = b2;
    go(OAG_MODE_IDX, 1'b0, pc);
  endtask
  task automatic res(input logic [15:0] ea, np);
    `CHK("ea", ea, o_res.ea)
    `CHK("next_pc", np, o_res.next_pc)
  endtask
  task automatic cost(input logic [3:0] cy, input logic [1:0] by);
    `CHK("cyc", cy, o_res.extra_cyc)
    `CHK("bytes", by, o_res.extra_bytes)
  endtask
  task automatic ld(input logic [1:0] s, input logic [15:0] v);
    @(posedge i_clk) #1;
    {i_ptr_wr, i_ptr_sel, i_ptr_data} = {1'b1, s, v};
    @(posedge i_clk) #1;
    i_ptr_wr = 1'b0;
  endtask
  task automatic t_plain;
    `CHK("page", 8'h00, o_page_base_register)
    go(OAG_MODE_INH, 1'b0, 16'h0100);
    res(16'h0000, 16'h0100);
    go(OAG_MODE_IMM, 1'b1, 16'h0200);
    res(16'h0200, 16'h0202);
    idx(8'h12, 8'h34, 8'h56, 16'h0300);
    go(OAG_MODE_EXT, 1'b0, 16'h0300);
    res(16'h1234, 16'h0302);
    {i_page_wr, i_page_data} = {1'b1, 8'h5A};
    @(posedge i_clk) #1;
    i_page_wr = 1'b0;
    idx(8'h77, 8'hFF, 8'hFF, 16'h0400);
    go(OAG_MODE_DIR, 1'b0, 16'h0400);
    res(16'h5A77, 16'h0401);
    idx(8'h9F, 8'h00, 8'h00, 16'h0500);
    go(OAG_MODE_REG, 1'b0, 16'h0500);
    `CHK("postbyte", 8'h9F, o_res.postbyte)
  endtask
  task automatic t_off5;
    logic [15:0] b [4] = '{16'h1000, 16'h2000, 16'h3000, 16'hFFFF};
    logic [4:0]  o [4] = '{5'h10, 5'h0F, 5'h01, 5'h01};
    for (int r = 0; r < 4; r++) begin
      idx({1'b0, 2'(r), o[r]}, 8'h00, 8'h00, 16'h0A00);
      res(b[r] + {{11{o[r][4]}}, o[r]}, 16'h0A01);
      `CHK("ptr", b[r], o_res.ptr_value)
    end
  endtask
  task automatic t_offs;
    idx(8'h88, 8'h80, 8'h00, 16'h0B00);
    res(16'h0F80, 16'h0B02);
    cost(4'h1, 2'h1);
    idx(8'h89, 8'h01, 8'hF4, 16'h0B10);
    res(16'h11F4, 16'h0B13);
    cost(4'h4, 2'h2);
    {hi_acc, lo_acc} = 16'h807F;
    idx(8'h86, 8'h00, 8'h00, 16'h0B20);
    res(16'h0F80, 16'h0B21);
    idx(8'h85, 8'h00, 8'h00, 16'h0B20);
    res(16'h107F, 16'h0B21);
    idx(8'h8B, 8'h00, 8'h00, 16'h0B20);
    res(16'h907F, 16'h0B21);
    cost(4'h4, 2'h0);
    `CHK("ptr", 16'h1000, o_res.ptr_value)
    idx(8'h84, 8'h00, 8'h00, 16'h0B30);
    res(16'h1000, 16'h0B31);
  endtask
  task automatic t_auto;
    logic [15:0] e [4] = '{16'h2000, 16'h2001, 16'h2002, 16'h2000};
    logic [15:0] q [4] = '{16'h2001, 16'h2003, 16'h2002, 16'h2000};
    for (int n = 0; n < 4; n++) begin
      idx(8'hA0 + 8'(n), 8'h00, 8'h00, 16'h0C00);
      res(e[n], 16'h0C01);
      `CHK("ptr", q[n], o_res.ptr_value)
      cost(4'h2 + 4'(n % 2), 2'h0);
    end
  endtask
  task automatic t_pcr_ind;
    idx(8'hEC, 8'h10, 8'h00, 16'h0600);
    res(16'h0612, 16'h0602);
    idx(8'h8D, 8'hFF, 8'h00, 16'h0700);
    res(16'h0603, 16'h0703);
    cost(4'h5, 2'h2);
    slow = 1'b1;
    idx(8'hF1, 8'h50, 8'h00, 16'h1010);
    idx(8'h98, 8'h10, 8'h00, 16'h0800);
    res(16'hF150, 16'h0802);
    cost(4'h4, 2'h1);
    idx(8'hAB, 8'hCD, 8'h00, 16'h2200);
    idx(8'h9F, 8'h22, 8'h00, 16'h0900);
    res(16'hABCD, 16'h0903);
    slow = 1'b0;
    idx(8'h87, 8'h00, 8'h00, 16'h0D00);
    `CHK("undef", 1'b1, o_res.undef)
    idx(8'h90, 8'h00, 8'h00, 16'h0D00);
    `CHK("undef", 1'b1, o_res.undef)
    `CHK("ptr", 16'h1000, o_res.ptr_value)
  endtask
  task automatic summarize;
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: whole run needs far fewer than 6000 cycles
  initial begin
    repeat (6000) @(posedge i_clk);
    err_total++;
    summarize();
  end
  initial begin
    {i_sys_rst, i_req, i_ptr_wr, i_page_wr, slow} = 5'b10000;
    {i_ptr_sel, i_ptr_data, i_page_data, hi_acc, lo_acc} = '0;
    i_req_data = '0;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    ld(2'h0, 16'h1000);
    ld(2'h1, 16'h2000);
    ld(2'h2, 16'h3000);
    ld(2'h3, 16'hFFFF);
    t_plain();
    t_off5();
    t_offs();
    t_auto();
    t_pcr_ind();
    summarize();
  end
endmodule
